// ### src/sbsr_pkg.sv
// package: status summary byte layout, mask layout and command codes
package sbsr_pkg;

  // ****************************************************************
  // status summary byte bit positions
  // ****************************************************************
  localparam int BIT_UNUSED   = 0;
  localparam int BIT_DEVSTAT  = 1;
  localparam int BIT_ERRQ     = 2;
  localparam int BIT_QUEST    = 3;
  localparam int BIT_MSGWAIT  = 4;
  localparam int BIT_STDEVT   = 5;
  localparam int BIT_MASTER   = 6;
  localparam int BIT_OPER     = 7;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int SUM_W   = 8;
  localparam int EVT_W   = 16;
  localparam int STD_W   = 8;
  localparam logic [SUM_W-1:0] MASK_RST    = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST     = 16'h0000;
  localparam logic [EVT_W-1:0] EVT_VALID   = 16'h7fff;
  localparam logic [STD_W-1:0] STD_RST     = 8'h00;
  localparam logic [SUM_W-1:0] SRC_MASK    = 8'hbe;

  // ****************************************************************
  // lower-level register selector
  // ****************************************************************
  typedef enum logic [1:0] {
    LVL_DEVICE,
    LVL_QUEST,
    LVL_OPER,
    LVL_STDEVT
  } sbsr_lvl_t;

  // ****************************************************************
  // host command port
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ_SUMMARY,
    CMD_SERIAL_POLL,
    CMD_WRITE_MASK,
    CMD_READ_MASK,
    CMD_READ_EVENT,
    CMD_WRITE_ENABLE,
    CMD_READ_ENABLE
  } sbsr_cmd_t;

  typedef struct packed {
    logic      valid;
    sbsr_cmd_t cmd;
    sbsr_lvl_t lvl;
    logic [EVT_W-1:0] data;
  } sbsr_req_t;

  typedef struct packed {
    logic             valid;
    logic [EVT_W-1:0] data;
  } sbsr_rsp_t;

  // one event pulse vector per lower-level register
  typedef struct packed {
    logic [EVT_W-1:0] device;
    logic [EVT_W-1:0] quest;
    logic [EVT_W-1:0] oper;
    logic [STD_W-1:0] stdevt;
  } sbsr_evt_t;

endpackage : sbsr_pkg

// ### src/sbsr_event_reg.sv
// module: one latching event register with enable mask and summary bit
`timescale 1ns/1ps
`default_nettype none

module sbsr_event_reg #(
  parameter int                W     = 16,
  parameter logic [W-1:0]      VALID = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] eventIn,
  input  wire logic         readClear,
  input  wire logic         enableWrite,
  input  wire logic [W-1:0] enableData,
  output logic      [W-1:0] eventBits,
  output logic      [W-1:0] enableBits,
  output logic              summary
);
  import sbsr_pkg::*;

  // anything wider than the host data word cannot be read back in one response
  if (W < 1 || W > EVT_W) begin : g_bad_width
    $error("sbsr_event_reg: width out of range");
  end

  logic [W-1:0] event_r;
  logic [W-1:0] enable_r;

  // ****************************************************************
  // event latch
  // ****************************************************************
  // a new event in the clearing cycle survives the read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      event_r <= '0;
    end else if (readClear) begin
      event_r <= eventIn & VALID;
    end else begin
      event_r <= (event_r | eventIn) & VALID;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_r <= '0;
    end else if (enableWrite) begin
      enable_r <= enableData & VALID;
    end
  end

  assign eventBits  = event_r;
  assign enableBits = enable_r;
  assign summary    = |(event_r & enable_r);

endmodule : sbsr_event_reg

`default_nettype wire

// ### src/sbsr_status_byte.sv
// module: status summary byte, service request mask and request output
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - bit 6 is derived from the other bits and the mask, never a source of its own.
// - the summary byte is returned on a summary query or a serial poll.
// - the mask has one bit per summary bit and its bit 6 takes no part in requests.
// - a rising enabled summary bit raises the service request line.
// - the mask is written by command and read back by query.
// - bit 1 is the summary of the device-state register.
// - bit 2 is high while the error queue holds an entry.
// - each new error queue entry raises a request when bit 2 is enabled.
// - bit 3 is the enabled summary of the questionable-state register.
// - bit 4 shows a message waiting in the output queue.
// - bit 5 is the enabled summary of the standard event register.
// - bit 7 is the enabled summary of the operation-state register.
// - each lower summary is the OR of its event bits ANDed with enables.
// - reading a lower event register clears it; events latch until read.
module sbsr_status_byte (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire sbsr_pkg::sbsr_req_t req,
  output sbsr_pkg::sbsr_rsp_t  rsp,
  input  wire sbsr_pkg::sbsr_evt_t events,
  input  wire logic            errQueueNotEmpty,
  input  wire logic            errQueuePush,
  input  wire logic            messageWaiting,
  input  wire logic            srqAck,
  output logic                 serviceRequest,
  output logic [7:0]           statusSummaryByte
);
  import sbsr_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // byte port is fixed at eight bits; std register rides in the data word
  if (SUM_W != 8 || STD_W > EVT_W) begin : g_bad_width
    $error("sbsr_status_byte: package widths do not fit the ports");
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  function automatic logic isCmd(sbsr_req_t r, sbsr_cmd_t c);
    return r.valid && (r.cmd == c);
  endfunction : isCmd

  function automatic logic isLvl(sbsr_req_t r, sbsr_cmd_t c, sbsr_lvl_t l);
    return isCmd(r, c) && (r.lvl == l);
  endfunction : isLvl

  // shared by all four lower levels of the read path
  function automatic logic [EVT_W-1:0] pickEvt(sbsr_cmd_t c, logic [EVT_W-1:0] evt,
                                               logic [EVT_W-1:0] en);
    return (c == CMD_READ_EVENT) ? evt : en;
  endfunction : pickEvt

  // ****************************************************************
  // lower-level registers
  // ****************************************************************
  logic [EVT_W-1:0] devEvt, devEn, qstEvt, qstEn, opEvt, opEn;
  logic [STD_W-1:0] stdEvt, stdEn;
  logic             devSum, qstSum, opSum, stdSum;

  sbsr_event_reg #(.W(EVT_W), .VALID(EVT_VALID)) u_dev (
    .clk         (clk),
    .rst_b       (rst_b),
    .eventIn     (events.device),
    .readClear   (isLvl(req, CMD_READ_EVENT, LVL_DEVICE)),
    .enableWrite (isLvl(req, CMD_WRITE_ENABLE, LVL_DEVICE)),
    .enableData  (req.data),
    .eventBits   (devEvt),
    .enableBits  (devEn),
    .summary     (devSum)
  );

  sbsr_event_reg #(.W(EVT_W), .VALID(EVT_VALID)) u_qst (
    .clk         (clk),
    .rst_b       (rst_b),
    .eventIn     (events.quest),
    .readClear   (isLvl(req, CMD_READ_EVENT, LVL_QUEST)),
    .enableWrite (isLvl(req, CMD_WRITE_ENABLE, LVL_QUEST)),
    .enableData  (req.data),
    .eventBits   (qstEvt),
    .enableBits  (qstEn),
    .summary     (qstSum)
  );

  sbsr_event_reg #(.W(EVT_W), .VALID(EVT_VALID)) u_op (
    .clk         (clk),
    .rst_b       (rst_b),
    .eventIn     (events.oper),
    .readClear   (isLvl(req, CMD_READ_EVENT, LVL_OPER)),
    .enableWrite (isLvl(req, CMD_WRITE_ENABLE, LVL_OPER)),
    .enableData  (req.data),
    .eventBits   (opEvt),
    .enableBits  (opEn),
    .summary     (opSum)
  );

  sbsr_event_reg #(.W(STD_W), .VALID(8'hff)) u_std (
    .clk         (clk),
    .rst_b       (rst_b),
    .eventIn     (events.stdevt),
    .readClear   (isLvl(req, CMD_READ_EVENT, LVL_STDEVT)),
    .enableWrite (isLvl(req, CMD_WRITE_ENABLE, LVL_STDEVT)),
    .enableData  (req.data[STD_W-1:0]),
    .eventBits   (stdEvt),
    .enableBits  (stdEn),
    .summary     (stdSum)
  );

  // ****************************************************************
  // summary byte and service request
  // ****************************************************************
  logic [SUM_W-1:0] mask_r;
  logic [SUM_W-1:0] srcBits;
  logic [SUM_W-1:0] srcPrev_r;
  logic             srqDrop;
  logic             srq_r;
  logic             masterBit;
  logic             riseHit;

  always_comb begin
    srcBits              = '0;
    srcBits[BIT_UNUSED]  = 1'b0;
    srcBits[BIT_DEVSTAT] = devSum;
    srcBits[BIT_ERRQ]    = errQueueNotEmpty;
    srcBits[BIT_QUEST]   = qstSum;
    srcBits[BIT_MSGWAIT] = messageWaiting;
    srcBits[BIT_STDEVT]  = stdSum;
    srcBits[BIT_OPER]    = opSum;
  end

  // mask bit 6 and bit 0 are cut out by SRC_MASK
  assign masterBit = |(srcBits & mask_r & SRC_MASK);

  // a push while the queue is already non-empty has no rising edge, so count it too
  assign riseHit = (|(srcBits & ~srcPrev_r & mask_r & SRC_MASK))
                 || (errQueuePush && mask_r[BIT_ERRQ]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      srcPrev_r <= '0;
    end else begin
      srcPrev_r <= srcBits;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= MASK_RST;
    end else if (isCmd(req, CMD_WRITE_MASK)) begin
      mask_r <= req.data[SUM_W-1:0];
    end
  end

  // poll or acknowledge retires the request, as does losing every enabled source
  assign srqDrop = srqAck || isCmd(req, CMD_SERIAL_POLL) || !masterBit;

  // request held until a poll, an ack or loss of every enabled source; a new rise wins over the ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      srq_r <= 1'b0;
    end else if (riseHit) begin
      srq_r <= 1'b1;
    end else if (srqDrop) begin
      srq_r <= 1'b0;
    end
  end

  assign serviceRequest = srq_r;

  // ****************************************************************
  // response path
  // ****************************************************************
  logic [SUM_W-1:0] byteNow;
  assign byteNow = (srcBits & SRC_MASK) | (SUM_W'(masterBit) << BIT_MASTER);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statusSummaryByte <= '0;
    end else begin
      statusSummaryByte <= byteNow;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.data  <= EVT_RST;
      if (req.valid) begin
        unique case (req.cmd)
          CMD_READ_SUMMARY, CMD_SERIAL_POLL: begin
            rsp.data <= {8'h00, byteNow};
          end
          CMD_READ_MASK: begin
            rsp.data <= {8'h00, mask_r};
          end
          CMD_READ_EVENT, CMD_READ_ENABLE: begin
            unique case (req.lvl)
              LVL_DEVICE: rsp.data <= pickEvt(req.cmd, devEvt, devEn);
              LVL_QUEST:  rsp.data <= pickEvt(req.cmd, qstEvt, qstEn);
              LVL_OPER:   rsp.data <= pickEvt(req.cmd, opEvt, opEn);
              LVL_STDEVT: rsp.data <= pickEvt(req.cmd, {8'h00, stdEvt}, {8'h00, stdEn});
            endcase
          end
          default: begin
            rsp.data <= EVT_RST;
          end
        endcase
      end
    end
  end

endmodule : sbsr_status_byte

`default_nettype wire

// ### tb/sbsr_status_byte_props.sv
// checker: port-level properties of the status byte block
`timescale 1ns/1ps
`default_nettype none
module sbsr_status_byte_props (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire sbsr_pkg::sbsr_req_t req,
  input wire sbsr_pkg::sbsr_rsp_t rsp,
  input wire logic                errQueueNotEmpty,
  input wire logic                messageWaiting,
  input wire logic                serviceRequest,
  input wire logic [7:0]          statusSummaryByte
);
  import sbsr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_zero; statusSummaryByte[0] == 1'b0; endproperty
  a_zero: assert property (p_zero) else $error("bit 0 set");
  property p_rsp; req.valid |=> rsp.valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no response");
  property p_mask;
    (req.valid && req.cmd == CMD_READ_MASK && $past(req.valid && req.cmd == CMD_WRITE_MASK))
      |=> rsp.data == {8'h00, $past(req.data[7:0], 2)};
  endproperty
  a_mask: assert property (p_mask) else $error("mask readback");
  property p_sum;
    (req.valid && (req.cmd == CMD_READ_SUMMARY || req.cmd == CMD_SERIAL_POLL))
      |=> rsp.data[15:8] == 8'h00 && rsp.data[0] == 1'b0;
  endproperty
  a_sum: assert property (p_sum) else $error("summary reply form");
  property p_errq; $past(rst_b) |-> statusSummaryByte[2] == $past(errQueueNotEmpty); endproperty
  a_errq: assert property (p_errq) else $error("error queue bit");
  property p_msg; $past(rst_b) |-> statusSummaryByte[4] == $past(messageWaiting); endproperty
  a_msg: assert property (p_msg) else $error("message bit");
  property p_mss; statusSummaryByte[6] |-> (statusSummaryByte & SRC_MASK) != 8'h00; endproperty
  a_mss: assert property (p_mss) else $error("master bit alone");
  property p_srq; $rose(serviceRequest) |-> statusSummaryByte[6]; endproperty
  a_srq: assert property (p_srq) else $error("request without master bit");
endmodule : sbsr_status_byte_props
bind sbsr_status_byte sbsr_status_byte_props u_props (.clk(clk), .rst_b(rst_b), .req(req),
  .rsp(rsp), .errQueueNotEmpty(errQueueNotEmpty), .messageWaiting(messageWaiting),
  .serviceRequest(serviceRequest), .statusSummaryByte(statusSummaryByte));
`default_nettype wire

// ### tb/sbsr_ctrl_model.sv
// partner: bus controller that acknowledges service requests
`timescale 1ns/1ps
`default_nettype none
module sbsr_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] ackDelay,
  input  wire logic       serviceRequest,
  output logic            srqAck
);
  logic [3:0] waitCnt_r;
  // zero delay leaves requests pending, as a busy controller would
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_r <= 4'h0;
      srqAck    <= 1'b0;
    end else if (serviceRequest && !srqAck && ackDelay != 4'h0) begin
      waitCnt_r <= waitCnt_r + 4'h1;
      srqAck    <= (waitCnt_r + 4'h1 == ackDelay);
    end else begin
      waitCnt_r <= 4'h0;
      srqAck    <= 1'b0;
    end
  end
endmodule : sbsr_ctrl_model
`default_nettype wire

// ### tb/sbsr_status_byte_tb.sv
// testbench: status byte, mask and service request scenarios
`timescale 1ns/1ps
`default_nettype none
module sbsr_status_byte_tb;
  import sbsr_pkg::*;
  logic        clk, rst_b, errQueueNotEmpty, errQueuePush, messageWaiting, srqAck, serviceRequest;
  sbsr_req_t   req;
  sbsr_rsp_t   rsp;
  sbsr_evt_t   events;
  logic [7:0]  statusSummaryByte;
  logic [3:0]  ackDelay;
  logic [15:0] rd;
  int          failures = 0, checked = 0, cycles = 0;
  sbsr_status_byte dut (.clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp), .events(events),
    .errQueueNotEmpty(errQueueNotEmpty), .errQueuePush(errQueuePush),
    .messageWaiting(messageWaiting), .srqAck(srqAck), .serviceRequest(serviceRequest),
    .statusSummaryByte(statusSummaryByte));
  sbsr_ctrl_model ctrl (.clk(clk), .rst_b(rst_b), .ackDelay(ackDelay),
    .serviceRequest(serviceRequest), .srqAck(srqAck));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end
  // ****
  // tasks
  // ****
  task automatic results;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // leaves valid high so a following call is back to back
  task automatic cmd(input sbsr_cmd_t c, input sbsr_lvl_t l, input logic [15:0] d);
    req = '{1'b1, c, l, d};
    step(1);
    chk("rsp valid", 16'h0001, {15'h0000, rsp.valid});
    rd = rsp.data;
  endtask : cmd
  task automatic pulse(input sbsr_lvl_t l, input logic [15:0] b);
    case (l)
      LVL_DEVICE: events.device = b;
      LVL_QUEST:  events.quest = b;
      LVL_OPER:   events.oper = b;
      default:    events.stdevt = b[7:0];
    endcase
    step(1);
    events = '0;
    step(2);
  endtask : pulse
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    chk("byte", 16'h0000, {8'h00, statusSummaryByte});
    cmd(CMD_READ_MASK, LVL_DEVICE, 16'h0000);
    chk("mask reset", {8'h00, MASK_RST}, rd);
    cmd(CMD_NONE, LVL_DEVICE, 16'h00ff);
    chk("idle cmd", 16'h0000, rd);
    cmd(CMD_WRITE_MASK, LVL_DEVICE, 16'h00ff);
    cmd(CMD_READ_MASK, LVL_DEVICE, 16'h0000);
    chk("mask", 16'h00ff, rd);
    cmd(CMD_WRITE_MASK, LVL_DEVICE, 16'h0041);
    req.valid = 1'b0;
    messageWaiting = 1'b1;
    step(3);
    chk("byte", 16'h0010, {8'h00, statusSummaryByte});
    chk("srq", 16'h0000, {15'h0000, serviceRequest});
    cmd(CMD_READ_SUMMARY, LVL_DEVICE, 16'h0000);
    chk("query", 16'h0010, rd);
    req.valid = 1'b0;
    messageWaiting = 1'b0;
    step(3);
    chk("byte", 16'h0000, {8'h00, statusSummaryByte});
    // plain rise of an enabled bit, then loss of the only source
    cmd(CMD_WRITE_MASK, LVL_DEVICE, 16'h0010);
    req.valid = 1'b0;
    messageWaiting = 1'b1;
    step(2);
    chk("srq", 16'h0001, {15'h0000, serviceRequest});
    chk("byte", 16'h0050, {8'h00, statusSummaryByte});
    messageWaiting = 1'b0;
    step(2);
    chk("srq", 16'h0000, {15'h0000, serviceRequest});
  endtask : t_reset
  task automatic t_errq;
    cmd(CMD_WRITE_MASK, LVL_DEVICE, 16'h0004);
    req.valid = 1'b0;
    errQueueNotEmpty = 1'b1;
    errQueuePush = 1'b1;
    step(1);
    errQueuePush = 1'b0;
    step(2);
    chk("srq", 16'h0001, {15'h0000, serviceRequest});
    chk("byte", 16'h0044, {8'h00, statusSummaryByte});
    cmd(CMD_SERIAL_POLL, LVL_DEVICE, 16'h0000);
    chk("poll", 16'h0044, rd);
    req.valid = 1'b0;
    step(1);
    chk("srq", 16'h0000, {15'h0000, serviceRequest});
    errQueuePush = 1'b1;
    step(1);
    errQueuePush = 1'b0;
    step(2);
    chk("srq", 16'h0001, {15'h0000, serviceRequest});
    ackDelay = 4'h3;
    step(6);
    chk("srq", 16'h0000, {15'h0000, serviceRequest});
    ackDelay = 4'h0;
    errQueueNotEmpty = 1'b0;
    step(3);
    chk("byte", 16'h0000, {8'h00, statusSummaryByte});
  endtask : t_errq
  task automatic t_levels;
    sbsr_lvl_t lv[4] = '{LVL_DEVICE, LVL_QUEST, LVL_OPER, LVL_STDEVT};
    int        pos[4] = '{BIT_DEVSTAT, BIT_QUEST, BIT_OPER, BIT_STDEVT};
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_WRITE_ENABLE, lv[i], 16'h0001);
      cmd(CMD_READ_ENABLE, lv[i], 16'h0000);
      chk("enable", 16'h0001, rd);
      req.valid = 1'b0;
      pulse(lv[i], 16'h0002);
      chk("masked", 16'h0000, {8'h00, statusSummaryByte});
      pulse(lv[i], 16'h0001);
      chk("sum", 16'h0001 << pos[i], {8'h00, statusSummaryByte});
      cmd(CMD_READ_EVENT, lv[i], 16'h0000);
      chk("event", 16'h0003, rd);
      req.valid = 1'b0;
      step(2);
      chk("cleared", 16'h0000, {8'h00, statusSummaryByte});
    end
  endtask : t_levels
  // reset in mid-run with a source present must bring the mask back
  task automatic t_rerst;
    cmd(CMD_WRITE_MASK, LVL_DEVICE, 16'h00ff);
    req.valid = 1'b0;
    messageWaiting = 1'b1;
    rst_b = 1'b0;
    step(2);
    chk("byte in reset", 16'h0000, {8'h00, statusSummaryByte});
    rst_b = 1'b1;
    step(1);
    cmd(CMD_READ_MASK, LVL_DEVICE, 16'h0000);
    chk("mask after reset", {8'h00, MASK_RST}, rd);
    req.valid = 1'b0;
    messageWaiting = 1'b0;
  endtask : t_rerst
  initial begin
    rst_b = 1'b0;
    req = '0;
    events = '0;
    errQueueNotEmpty = 1'b0;
    errQueuePush = 1'b0;
    messageWaiting = 1'b0;
    ackDelay = 4'h0;
    step(20);
    rst_b = 1'b1;
    step(1);
    t_reset();
    t_errq();
    t_levels();
    t_rerst();
    results();
  end
endmodule : sbsr_status_byte_tb
`default_nettype wire
